// file: rtl/pfa_consts.svh
// Named constants of the frame alignment receiver.
// Assumes inclusion by bare name from rtl/ files only.
`ifndef PFA_CONSTS_SVH
`define PFA_CONSTS_SVH

`define PFA_CNT_BITS        9
`define PFA_WORD_A          7'h1B
`define PFA_TS0_LAST        8'h07
`define PFA_TS0_END_A       9'h007
`define PFA_SLOT15_BIT8     8'h7F
`define PFA_SLOT30_BIT8_A   9'h0F7
`define PFA_LOSS_LIMIT      2'h3
`define PFA_LOSS_PRIOR      2'h2
`define PFA_RATE_LIMIT      4'hF
`define PFA_RUN_LAST        4'h7
`define PFA_RUN_LEN         4'h8
`define PFA_GROUP_LAST      3'h7
`define PFA_INTERVAL_MS     512
`define PFA_DOUBLE_FRAME_US 250
`define PFA_INTERVAL_TICKS  ((`PFA_INTERVAL_MS * 1000) / `PFA_DOUBLE_FRAME_US)
`define PFA_INTERVAL_BITS   11

`endif

// file: rtl/pfa_pkg.sv
// Types shared by the frame alignment receiver.
// Assumes nothing of its surroundings.
`default_nettype none

package pfa_pkg;

  typedef enum logic [2:0] {
    PFA_SEARCH,
    PFA_CHECK_B,
    PFA_SKIP,
    PFA_CHECK_A2,
    PFA_ALIGNED
  } pfa_state_t;

endpackage : pfa_pkg

`default_nettype wire

// file: rtl/pfa_rate_mon.sv
// Error-rate monitor: counts missing frame-A words per interval.
// Assumes one-cycle tick and error pulses from the same clock.
`timescale 1ns/1ns
`default_nettype none
`include "pfa_consts.svh"

module pfa_rate_mon #(
  parameter int INTERVAL_BITS = `PFA_INTERVAL_BITS
) (
  input  wire logic sys_clk_in,
  input  wire logic rst_in,
  input  wire logic ce_in,
  input  wire logic clr_in,
  input  wire logic frame_tick_in,
  input  wire logic err_in,
  input  wire logic fast_in,
  output logic      error_rate_alarm_out,
  output logic      interval_end_out
);

  logic [INTERVAL_BITS-1:0] ivl;
  logic [3:0]               err_cnt;
  logic [3:0]               next_err;
  logic [3:0]               grp_err;
  logic [3:0]               next_grp;
  logic [3:0]               hi_run;
  logic [2:0]               grp_idx;
  logic                     adv;
  logic                     ivl_end;

  if (INTERVAL_BITS < 2 || INTERVAL_BITS > 16) begin : g_chk
    $error("pfa_rate_mon: INTERVAL_BITS out of range");
  end

  // Test speed-up advances the interval timer every cycle
  assign adv      = fast_in || frame_tick_in;
  assign ivl_end  = adv && (&ivl);
  assign next_err = (err_in && err_cnt != `PFA_RATE_LIMIT) ? 4'(err_cnt + 4'h1) : err_cnt;
  assign next_grp = (err_in && grp_err != `PFA_RATE_LIMIT) ? 4'(grp_err + 4'h1) : grp_err;

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ivl <= '0;
    end else if (ce_in) begin
      if (clr_in) ivl <= '0;
      else if (adv) ivl <= INTERVAL_BITS'(ivl + 1'b1);
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      err_cnt <= 4'h0;
      grp_err <= 4'h0;
      grp_idx <= 3'h0;
      hi_run  <= 4'h0;
    end else if (ce_in) begin
      if (clr_in) begin
        err_cnt <= 4'h0;
        grp_err <= 4'h0;
        grp_idx <= 3'h0;
        hi_run  <= 4'h0;
      end else if (ivl_end) begin
        err_cnt <= 4'h0;
        grp_idx <= 3'(grp_idx + 3'h1);
        grp_err <= (grp_idx == `PFA_GROUP_LAST) ? 4'h0 : next_grp;
        if (next_err != `PFA_RATE_LIMIT) hi_run <= 4'h0;
        else if (hi_run != `PFA_RUN_LEN) hi_run <= 4'(hi_run + 4'h1);
      end else begin
        err_cnt <= next_err;
        grp_err <= next_grp;
      end
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      error_rate_alarm_out <= 1'b0;
      interval_end_out     <= 1'b0;
    end else if (ce_in) begin
      interval_end_out <= ivl_end && !clr_in;
      if (clr_in) begin
        error_rate_alarm_out <= 1'b0;
      end else if (ivl_end && next_err == `PFA_RATE_LIMIT && hi_run >= `PFA_RUN_LAST) begin
        error_rate_alarm_out <= 1'b1;
      end else if (ivl_end && grp_idx == `PFA_GROUP_LAST && next_grp != `PFA_RATE_LIMIT) begin
        error_rate_alarm_out <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in || !ce_in || clr_in);

  a_rate_set: assert property (
    (ivl_end && next_err == `PFA_RATE_LIMIT && hi_run >= `PFA_RUN_LAST) |=> error_rate_alarm_out)
    else $error("error-rate alarm not raised after eight bad intervals");

  a_rate_clear: assert property (
    (ivl_end && grp_idx == `PFA_GROUP_LAST && next_grp != `PFA_RATE_LIMIT)
      |=> !error_rate_alarm_out)
    else $error("error-rate alarm not cleared after quiet group");

endmodule : pfa_rate_mon

`default_nettype wire

// file: rtl/pfa_receiver.sv
// Receive timing and frame alignment for a 30-channel 2.048 Mbit/s link.
// Assumes decoded NRZ data and line clock from a line decoder, sampled here.
//
// Functional notes
// - Word A: bit 1 ignored, bits 2 to 8 equal 0011011.
// - Word B: bit 2 equals 1, all other bits ignored.
// - Three consecutive errored expected words mean alignment lost.
// - Regain needs A, then B, then A in successive frames.
// - A without following B restarts the A search one frame later.
// - Nine-stage counter on line clock; every stage driven out.
// - One-bit pulse on bit 8 of slot 15.
// - One-bit pulse on bit 8 of slot 30, frame A.
// - Three errored words set the alignment alarm latch.
// - External forcing input also sets the alarm latch.
// - Alarm latch state shown continuously on the loss alarm output.
// - Missing-word alarm set on absent A word, cleared by present A.
// - Rate alarm when 15 errored A words per interval, eight times running.
// - Rate alarm cleared when under 15 missing A words over eight intervals.
// - Interval timed by an 11-bit counter stepping once per double frame.
// - Three test points and a master reset input for test.
`timescale 1ns/1ns
`default_nettype none
`include "pfa_consts.svh"

module pfa_receiver
  import pfa_pkg::*;
#(
  parameter int INTERVAL_BITS = `PFA_INTERVAL_BITS
) (
  input  wire logic                     sys_clk_in,
  input  wire logic                     rst_in,
  input  wire logic                     ce_in,
  input  wire logic                     line_clock_in,
  input  wire logic                     line_data_in,
  input  wire logic                     forced_alarm_in,
  input  wire logic                     master_reset_test_n_in,
  input  wire logic                     test_point_one_in,
  output logic      [`PFA_CNT_BITS-1:0] timing_counter_taps_out,
  output logic                          slot15_marker_pulse_out,
  output logic                          slot30_preset_pulse_out,
  output logic                          alignment_loss_alarm_out,
  output logic                          word_missing_alarm_out,
  output logic                          error_rate_alarm_out,
  output logic                          test_point_two_out,
  output logic                          test_point_three_out
);

  // ****************************************************************
  // Pin synchronisation
  // ****************************************************************

  logic [4:0]               pins_s;
  logic                     lclk_s;
  logic                     data_s;
  logic                     force_s;
  logic                     mr_n_s;
  logic                     fast_s;
  logic                     lclk_d;
  logic                     bit_stb;
  logic                     eval_stb;
  logic                     clr;

  if (INTERVAL_BITS != `PFA_INTERVAL_BITS && INTERVAL_BITS > `PFA_INTERVAL_BITS) begin : g_chk
    $error("pfa_receiver: INTERVAL_BITS above the documented width");
  end

  pfa_sync #(
    .WIDTH (5)
  ) u_sync (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .ce_in      (ce_in),
    .async_in   ({line_clock_in, line_data_in, forced_alarm_in,
                  master_reset_test_n_in, test_point_one_in}),
    .sync_out   (pins_s)
  );

  assign lclk_s  = pins_s[4];
  assign data_s  = pins_s[3];
  assign force_s = pins_s[2];
  assign mr_n_s  = pins_s[1];
  assign fast_s  = pins_s[0];
  assign clr     = !mr_n_s;

  // Data and clock share the same sync delay, so data is sampled mid-bit
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      lclk_d   <= 1'b0;
      eval_stb <= 1'b0;
    end else if (ce_in) begin
      lclk_d   <= lclk_s;
      eval_stb <= bit_stb;
    end
  end

  assign bit_stb = lclk_s && !lclk_d;

  // ****************************************************************
  // Line timing
  // ****************************************************************

  logic [`PFA_CNT_BITS-1:0] cnt;
  logic [7:0]               sr;
  logic                     preset_evt;

  // Bits 2:0 bit in slot, 7:3 slot number, 8 frame B
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt <= '0;
    end else if (ce_in) begin
      if (clr) cnt <= '0;
      else if (preset_evt) cnt <= `PFA_TS0_END_A;
      else if (bit_stb) cnt <= `PFA_CNT_BITS'(cnt + 1'b1);
    end
  end

  assign timing_counter_taps_out = cnt;

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sr <= 8'h00;
    end else if (ce_in) begin
      if (bit_stb) sr <= {sr[6:0], data_s};
    end
  end

  // Markers lag the counter by one system cycle, still one bit wide
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      slot15_marker_pulse_out <= 1'b0;
      slot30_preset_pulse_out <= 1'b0;
    end else if (ce_in) begin
      slot15_marker_pulse_out <= !clr && (cnt[7:0] == `PFA_SLOT15_BIT8);
      slot30_preset_pulse_out <= !clr && (cnt == `PFA_SLOT30_BIT8_A);
    end
  end

  // ****************************************************************
  // Word checks
  // ****************************************************************

  logic                     hit_a;
  logic                     hit_b;
  logic                     frame_b;
  logic                     hit_frame;
  logic                     ts0_eval;
  logic                     frame_tick;

  // Newest bit is position 8 of the slot
  assign hit_a      = (sr[6:0] == `PFA_WORD_A);
  assign hit_b      = sr[6];
  assign frame_b    = cnt[8];
  assign hit_frame  = frame_b ? hit_b : hit_a;
  assign ts0_eval   = eval_stb && (cnt[7:0] == `PFA_TS0_LAST);
  assign frame_tick = eval_stb && (cnt == `PFA_TS0_END_A);

  // ****************************************************************
  // Alignment state machine
  // ****************************************************************

  pfa_state_t               state;
  pfa_state_t               next_state;
  logic [1:0]               miss;
  logic [1:0]               next_miss;
  logic                     loss_evt;
  logic                     regain_evt;

  always_comb begin
    next_state = state;
    next_miss  = miss;
    preset_evt = 1'b0;
    loss_evt   = 1'b0;
    regain_evt = 1'b0;
    unique case (state)
      PFA_SEARCH: begin
        // Any bit position may start a frame while searching
        if (eval_stb && hit_a) begin
          preset_evt = 1'b1;
          next_state = PFA_CHECK_B;
        end
      end
      PFA_CHECK_B: begin
        if (ts0_eval) begin
          next_state = hit_b ? PFA_CHECK_A2 : PFA_SKIP;
        end
      end
      PFA_SKIP: begin
        // Skipping a frame defeats imitative patterns
        if (ts0_eval) begin
          next_state = PFA_SEARCH;
        end
      end
      PFA_CHECK_A2: begin
        if (ts0_eval) begin
          if (hit_a) begin
            next_state = PFA_ALIGNED;
            next_miss  = 2'h0;
            regain_evt = 1'b1;
          end else begin
            next_state = PFA_SEARCH;
          end
        end
      end
      PFA_ALIGNED: begin
        if (ts0_eval) begin
          if (hit_frame) begin
            next_miss = 2'h0;
          end else if (2'(miss + 2'h1) == `PFA_LOSS_LIMIT) begin
            next_miss  = 2'h0;
            loss_evt   = 1'b1;
            next_state = PFA_SEARCH;
          end else begin
            next_miss = 2'(miss + 2'h1);
          end
        end
      end
      default: begin
        next_state = PFA_SEARCH;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state <= PFA_SEARCH;
      miss  <= 2'h0;
    end else if (ce_in) begin
      if (clr) begin
        state <= PFA_SEARCH;
        miss  <= 2'h0;
      end else begin
        state <= next_state;
        miss  <= next_miss;
      end
    end
  end

  // ****************************************************************
  // Alarms
  // ****************************************************************

  logic                     rate_err;

  // Set-reset latch; set wins over the regain release
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      alignment_loss_alarm_out <= 1'b0;
    end else if (ce_in) begin
      if (clr) alignment_loss_alarm_out <= 1'b0;
      else if (loss_evt || force_s) alignment_loss_alarm_out <= 1'b1;
      else if (regain_evt) alignment_loss_alarm_out <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      word_missing_alarm_out <= 1'b0;
    end else if (ce_in) begin
      if (clr) begin
        word_missing_alarm_out <= 1'b0;
      end else if (ts0_eval && !frame_b &&
                   (state == PFA_ALIGNED || state == PFA_CHECK_A2)) begin
        word_missing_alarm_out <= !hit_a;
      end
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      test_point_two_out <= 1'b0;
    end else if (ce_in) begin
      test_point_two_out <= !clr && (next_state == PFA_ALIGNED);
    end
  end

  assign rate_err = ts0_eval && !frame_b && !hit_a && (state == PFA_ALIGNED);

  pfa_rate_mon #(
    .INTERVAL_BITS (INTERVAL_BITS)
  ) u_rate (
    .sys_clk_in           (sys_clk_in),
    .rst_in               (rst_in),
    .ce_in                (ce_in),
    .clr_in               (clr),
    .frame_tick_in        (frame_tick),
    .err_in               (rate_err),
    .fast_in              (fast_s),
    .error_rate_alarm_out (error_rate_alarm_out),
    .interval_end_out     (test_point_three_out)
  );

  // ****************************************************************
  // Checks
  // ****************************************************************

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in || !ce_in || clr);

  sequence s_bit_at(logic [7:0] v);
    bit_stb ##1 (cnt[7:0] == v);
  endsequence

  sequence s_bad_third;
    (state == PFA_ALIGNED) && ts0_eval && !hit_frame && (miss == `PFA_LOSS_PRIOR);
  endsequence

  a_counter_step: assert property (
    bit_stb |=> (cnt == `PFA_CNT_BITS'($past(cnt) + 1'b1)))
    else $error("timing counter did not advance on line bit");

  a_slot15_mark: assert property (
    s_bit_at(`PFA_SLOT15_BIT8) |=> slot15_marker_pulse_out)
    else $error("slot 15 marker missing");

  a_slot30_mark: assert property (
    (bit_stb ##1 (cnt == `PFA_SLOT30_BIT8_A)) |=> slot30_preset_pulse_out)
    else $error("slot 30 preset pulse missing");

  a_search_lock: assert property (
    (state == PFA_SEARCH && eval_stb && hit_a)
      |=> (state == PFA_CHECK_B && cnt == `PFA_TS0_END_A))
    else $error("word A not taken as frame start");

  a_word_b_step: assert property (
    (state == PFA_CHECK_B && ts0_eval && hit_b) |=> (state == PFA_CHECK_A2))
    else $error("word B not accepted");

  a_skip_frame: assert property (
    (state == PFA_CHECK_B && ts0_eval && !hit_b) |=> (state == PFA_SKIP)[*8])
    else $error("search restarted without skipping a frame");

  a_three_miss: assert property (
    s_bad_third |=> (state == PFA_SEARCH && alignment_loss_alarm_out))
    else $error("third errored word did not drop alignment");

  a_force_alarm: assert property (
    force_s |=> alignment_loss_alarm_out)
    else $error("forcing input did not set the alarm");

  a_word_missing: assert property (
    (state == PFA_ALIGNED && ts0_eval && !frame_b && !hit_a) |=> word_missing_alarm_out)
    else $error("missing-word alarm not raised");

  a_master_clear: assert property (
    @(posedge sys_clk_in) disable iff (rst_in || !ce_in)
    clr |=> (state == PFA_SEARCH && cnt == '0 && !word_missing_alarm_out))
    else $error("master reset did not clear the block");

endmodule : pfa_receiver

`default_nettype wire

// file: rtl/pfa_sync.sv
// Two-flop synchroniser for pin inputs.
// Assumes a single system clock; inputs may change at any time.
`timescale 1ns/1ns
`default_nettype none

module pfa_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             sys_clk_in,
  input  wire logic             rst_in,
  input  wire logic             ce_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  if (WIDTH < 1) begin : g_chk
    $error("pfa_sync: WIDTH must be at least 1");
  end

  // First stage feeds the second stage only
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      stage1   <= '0;
      sync_out <= '0;
    end else if (ce_in) begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule : pfa_sync

`default_nettype wire

// file: verif/pfa_line_src.sv
// Line decoder stand-in: serialises frames as NRZ data with a line clock.
// Assumes one caller at a time, driving from the falling system clock edge.
`timescale 1ns/1ns
`default_nettype none

module pfa_line_src (
  input  wire logic sys_clk_in,
  output logic      line_clock_out,
  output logic      line_data_out
);
  // ****
  // Bit and frame senders
  // ****
  initial begin
    line_clock_out = 1'b0;
    line_data_out  = 1'b1;
  end

  // Seven system cycles a bit: data settles before the rise, low phase 3
  task automatic send_bit(input logic b);
    @(negedge sys_clk_in) line_data_out = b;
    repeat (2) @(negedge sys_clk_in);
    line_clock_out = 1'b1;
    repeat (4) @(negedge sys_clk_in);
    line_clock_out = 1'b0;
  endtask : send_bit

  // Slot zero first, position 1 leading; idle ones can never imitate word A
  task automatic send_frame(input logic [7:0] word);
    for (int i = 7; i >= 0; i--) send_bit(word[i]);
    for (int i = 0; i < 248; i++) send_bit(1'b1);
  endtask : send_frame
endmodule : pfa_line_src

`default_nettype wire

// file: verif/pfa_receiver_bench.sv
// Self-checking bench for the frame alignment receiver.
// Assumes the line source model and a shortened interval timer.
`timescale 1ns/1ns
`default_nettype none

module pfa_receiver_bench;
  localparam int         IVL_BITS   = 3;
  localparam int         BIT_CYCLES = 7;
  localparam logic [7:0] WA         = 8'h1B;
  localparam logic [7:0] WB         = 8'hFF;
  localparam logic [7:0] BAD_A      = 8'h1F;
  localparam logic [7:0] BAD_B      = 8'hBF;

  logic       sys_clk_in;
  logic       rst_in;
  logic       ce;
  logic       line_clock;
  logic       line_data;
  logic       forced_alarm;
  logic       master_reset_test_n;
  logic       test_point_one;
  logic [8:0] taps;
  logic       slot15_pulse;
  logic       slot30_pulse;
  logic       loss_alarm;
  logic       miss_alarm;
  logic       rate_alarm;
  logic       test_point_two;
  logic       test_point_three;
  int         failures;
  int         n_compared;
  int         w15;
  int         w30;
  int         n15;
  int         n30;
  int         gap;
  logic       mon_on;

  pfa_receiver #(.INTERVAL_BITS(IVL_BITS)) i_pfa_receiver (
    .sys_clk_in              (sys_clk_in),
    .rst_in                  (rst_in),
    .ce_in                   (ce),
    .line_clock_in           (line_clock),
    .line_data_in            (line_data),
    .forced_alarm_in         (forced_alarm),
    .master_reset_test_n_in  (master_reset_test_n),
    .test_point_one_in       (test_point_one),
    .timing_counter_taps_out (taps),
    .slot15_marker_pulse_out (slot15_pulse),
    .slot30_preset_pulse_out (slot30_pulse),
    .alignment_loss_alarm_out(loss_alarm),
    .word_missing_alarm_out  (miss_alarm),
    .error_rate_alarm_out    (rate_alarm),
    .test_point_two_out      (test_point_two),
    .test_point_three_out    (test_point_three)
  );

  pfa_line_src i_pfa_line_src (
    .sys_clk_in    (sys_clk_in),
    .line_clock_out(line_clock),
    .line_data_out (line_data)
  );

  // ****
  // Clock, compare and report
  // ****
  initial sys_clk_in = 1'b0;
  always #5 sys_clk_in = ~sys_clk_in;

  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check

  task automatic final_report;
    $display("Compared %0d, mismatched %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : final_report

  task automatic send(input logic [7:0] w);
    i_pfa_line_src.send_frame(w);
  endtask : send

  // Bounded wait; returns cycles spent until the interval-end pulse
  task automatic wait_tp3(output int n);
    n = 0;
    do begin
      @(negedge sys_clk_in);
      n++;
    end while (test_point_three !== 1'b1 && n < 100);
    if (test_point_three !== 1'b1) begin
      failures++;
      final_report();
    end
  endtask : wait_tp3

  // ****
  // Marker watch: position at the rise, width in system cycles
  // ****
  task automatic watch(input logic p, ref int w, ref int n,
                       input logic [8:0] seen, input logic [8:0] exp);
    if (p === 1'b1) begin
      if (w == 0) begin
        n++;
        check(seen, exp);
      end
      w++;
    end else if (w != 0) begin
      check(9'(w), 9'(BIT_CYCLES));
      w = 0;
    end
  endtask : watch

  always @(negedge sys_clk_in) begin
    if (!mon_on) begin
      w15 = 0;
      w30 = 0;
    end else begin
      watch(slot15_pulse, w15, n15, {1'b0, taps[7:0]}, 9'h07F);
      watch(slot30_pulse, w30, n30, taps, 9'h0F7);
    end
  end

  // Hang guard
  initial begin
    repeat (90000) @(posedge sys_clk_in);
    failures++;
    final_report();
  end

  // ****
  // Main sequence
  // ****
  initial begin
    rst_in              = 1'b1;
    ce                  = 1'b1;
    forced_alarm        = 1'b0;
    master_reset_test_n = 1'b0;
    test_point_one      = 1'b0;
    mon_on              = 1'b0;
    failures            = 0;
    n_compared          = 0;
    n15                 = 0;
    n30                 = 0;
    repeat (16) @(negedge sys_clk_in);
    rst_in = 1'b0;
    master_reset_test_n = 1'b1;
    repeat (4) @(negedge sys_clk_in);
    check(loss_alarm, 0);
    check(test_point_two, 0);
    mon_on = 1'b1;
    // Third frame's word A falls in the skipped frame
    send(WA);
    send(BAD_B);
    send(WA);
    send(WB);
    send(WA);
    check(test_point_two, 0);
    send(WB);
    check(test_point_two, 0);
    send(WA);
    check(test_point_two, 1);
    check(taps, 9'h0FF);
    check(loss_alarm, 0);
    check(miss_alarm, 0);
    n15 = 0;
    n30 = 0;
    send(WB);
    check(taps, 9'h1FF);
    check(9'(n15), 1);
    check(9'(n30), 0);
    send(BAD_A);
    check(9'(n15), 2);
    check(9'(n30), 1);
    check(miss_alarm, 1);
    check(loss_alarm, 0);
    send(WB);
    check(miss_alarm, 1);
    send(WA);
    check(miss_alarm, 0);
    // Errors split by good words never add up
    send(BAD_B);
    send(WA);
    send(BAD_B);
    send(WA);
    check(loss_alarm, 0);
    check(test_point_two, 1);
    send(BAD_B);
    send(BAD_A);
    check(loss_alarm, 0);
    send(BAD_B);
    check(loss_alarm, 1);
    check(test_point_two, 0);
    send(WB);
    check(loss_alarm, 1);
    send(WA);
    send(WB);
    send(WA);
    check(test_point_two, 1);
    check(loss_alarm, 0);
    check(miss_alarm, 0);
    forced_alarm = 1'b1;
    repeat (5) @(negedge sys_clk_in);
    check(loss_alarm, 1);
    forced_alarm = 1'b0;
    send(WB);
    check(loss_alarm, 1);
    mon_on = 1'b0;
    master_reset_test_n = 1'b0;
    repeat (6) @(negedge sys_clk_in);
    check(taps, 9'h000);
    check(loss_alarm, 0);
    check(miss_alarm, 0);
    check(test_point_two, 0);
    check(rate_alarm, 0);
    master_reset_test_n = 1'b1;
    test_point_one = 1'b1;
    wait_tp3(gap);
    wait_tp3(gap);
    check(9'(gap), 9'(2 ** IVL_BITS));
    // Enable low: timer and its pulse hold, then a full interval follows
    wait_tp3(gap);
    ce = 1'b0;
    repeat (5) @(negedge sys_clk_in);
    check(test_point_three, 1);
    ce = 1'b1;
    wait_tp3(gap);
    check(9'(gap), 9'(2 ** IVL_BITS));
    repeat (100) @(negedge sys_clk_in);
    check(rate_alarm, 0);
    final_report();
  end
endmodule : pfa_receiver_bench

`default_nettype wire
